// ==== hw/bbs_exec.sv ====
// Decode and execute of the no-overflow, nonzero, always-relative branches and bit set
//
// Contract
// - Upper byte e5 with signed 8-bit offset branches only when overflow is clear.
// - Upper byte e1 with signed 8-bit offset branches only when zero is clear.
// - Branch target is instruction address plus two plus twice the offset.
// - Conditional branch takes one cycle when not taken, two when taken.
// - Taken branch: decode, literal, compute, load PC, then a full idle cycle.
// - Relative branch always loads PC with incremented PC plus twice 11-bit offset.
// - Relative branch is recognised by top five bits 11010, offset below.
// - Relative branch always takes two cycles, second one idle throughout.
// - Bit set forces selected bit of addressed register to one, others kept.
// - Access flag zero selects access bank, ignoring the bank select value.
// - Access flag one forms address from bank select value and address field.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module bbs_exec
	import bbs_pkg::*;
#(
	parameter int         PC_W        = PC_W_DEF,
	parameter logic [7:0] ACC_SPLIT   = ACC_SPLIT_DEF,
	parameter logic [3:0] ACC_HI_BANK = ACC_HI_BANK_DEF
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// Fetch side
	input  wire logic [15:0]          instrWord,
	input  wire logic                 instrValid,
	input  wire logic [PC_W-1:0]      instrAddr,
	// Status flags from the datapath
	input  wire logic                 ovfFlag,
	input  wire logic                 zeroFlag,
	// Bank select value
	input  wire logic [BSR_W-1:0]     bankSel,
	// File register port
	output bbs_frreq_t                frReq,
	input  wire logic [7:0]           frRdData,
	// Program counter control
	output logic                      pcLoad,
	output logic [PC_W-1:0]           pcTarget,
	output logic                      fetchFlush,
	output logic                      nopCycle,
	output bbs_phase_t                qPhase,
	// Software register port
	input  wire logic [7:0]           swAddr,
	input  wire logic [31:0]          swWrData,
	input  wire logic                 swWr,
	input  wire logic                 swRd,
	output logic [31:0]               swRdData
);

	// Decode of one instruction word into kind and fields
	function automatic bbs_decoded_t decodeWord(input logic [15:0] w);
		bbs_decoded_t d;
		d        = '0;
		d.kind   = OPK_NONE;
		d.bitPos = w[BIT_POS_LSB +: 3];
		d.access = w[ACCESS_BIT];
		d.fAddr  = w[7:0];
		d.offset = {{(OFFSET_W-8){w[7]}}, w[7:0]};
		if (w[15:OP_BYTE_LSB] == OP_NO_OVF) begin
			d.kind = OPK_NOOVF;
		end else if (w[15:OP_BYTE_LSB] == OP_NONZERO) begin
			d.kind = OPK_NZ;
		end else if (w[15:OP_FIVE_LSB] == OP_ALWAYS) begin
			d.kind   = OPK_BRA;
			d.offset = w[OFFSET_W-1:0];
		end else if (w[15:OP_NIB_LSB] == OP_SETBIT) begin
			d.kind = OPK_BSF;
		end
		return d;
	endfunction : decodeWord

	// File register address from access flag, address field and bank select
	function automatic logic [FR_ADDR_W-1:0] fileAddr(
		input logic             access,
		input logic [7:0]       f,
		input logic [BSR_W-1:0] bank_select_value
	);
		logic [FR_ADDR_W-1:0] a;
		if (access) begin
			a = {bank_select_value, f};
		end else if (f < ACC_SPLIT) begin
			a = {ACC_LO_BANK, f};
		end else begin
			a = {ACC_HI_BANK, f};
		end
		return a;
	endfunction : fileAddr

	// Phase sequencer
	bbs_phase_t phase;

	bbs_qphase u_qphase (
		.clk    (clk),
		.resetn (resetn),
		.phase  (phase)
	);

	// Execute state
	bbs_state_t       stateReg,    stateNext;
	logic             nopReg,      nopNext;
	bbs_decoded_t     insReg,      insNext;
	logic [PC_W-1:0]  addrReg,     addrNext;
	bbs_frreq_t       frReg,       frNext;
	logic             pcLoadReg,   pcLoadNext;
	logic             flushReg,    flushNext;
	logic [PC_W-1:0]  targetReg,   targetNext;
	logic             takenReg,    takenNext;
	logic             foreignReg,  foreignNext;
	logic [31:0]      countReg,    countNext;

	// Software state
	logic [CTRL_W-1:0] ctrlReg,    ctrlNext;
	logic [31:0]       rdDataReg,  rdDataNext;

	// Combinational helpers
	bbs_decoded_t     decoded;
	logic [PC_W-1:0]  branchTarget;
	logic             condTrue;
	logic             isBranch;
	logic [7:0]       bitMask;

	assign decoded = decodeWord(instrWord);

	// Target from incremented address; offset doubled since words are two bytes
	always_comb begin
		branchTarget = PC_W'(addrReg + PC_W'(2)
			+ {{(PC_W-OFFSET_W-1){insReg.offset[OFFSET_W-1]}}, insReg.offset, 1'b0});
	end

	// Branch condition evaluated on the flags present in Q3
	always_comb begin
		condTrue = 1'b0;
		isBranch = 1'b0;
		case (insReg.kind)
			OPK_NOOVF: begin
				isBranch = 1'b1;
				condTrue = !ovfFlag;
			end
			OPK_NZ: begin
				isBranch = 1'b1;
				condTrue = !zeroFlag;
			end
			OPK_BRA: begin
				isBranch = 1'b1;
				condTrue = 1'b1;
			end
			default: begin
				isBranch = 1'b0;
				condTrue = 1'b0;
			end
		endcase
	end

	// One-hot mask of the bit to set
	always_comb begin
		bitMask = 8'h01 << insReg.bitPos;
	end

	// Execute sequencing across the four phases
	always_comb begin
		stateNext   = stateReg;
		nopNext     = nopReg;
		insNext     = insReg;
		addrNext    = addrReg;
		frNext      = frReg;
		frNext.rdEn = 1'b0;
		frNext.wrEn = 1'b0;
		pcLoadNext  = 1'b0;
		flushNext   = 1'b0;
		targetNext  = targetReg;
		takenNext   = takenReg;
		foreignNext = foreignReg;
		countNext   = countReg;
		case (phase)
			PH_Q1: begin
				// Idle cycle after a jump swallows the discarded prefetch
				if (stateReg == ST_RUN && instrValid && ctrlReg[CTRL_BIT_EN]) begin
					insNext     = decoded;
					addrNext    = instrAddr;
					foreignNext = (decoded.kind == OPK_NONE);
					if (decoded.kind == OPK_BSF) begin
						frNext.rdEn = 1'b1;
						frNext.addr = fileAddr(decoded.access, decoded.fAddr, bankSel);
					end
				end else begin
					insNext      = '0;
					insNext.kind = OPK_NONE;
				end
			end
			PH_Q2: begin
				// Offset literal already held in the decoded word
				insNext = insReg;
			end
			PH_Q3: begin
				if (isBranch) begin
					takenNext  = condTrue;
					targetNext = branchTarget;
					pcLoadNext = condTrue;
					flushNext  = condTrue;
				end else if (insReg.kind == OPK_BSF) begin
					// Only the data byte is touched, never a status flag
					frNext.wrEn   = 1'b1;
					frNext.wrData = frRdData | bitMask;
				end
			end
			PH_Q4: begin
				if (stateReg == ST_NOP) begin
					stateNext = ST_RUN;
					nopNext   = 1'b0;
				end else if (pcLoadReg) begin
					stateNext = ST_NOP;
					nopNext   = 1'b1;
				end
				if (insReg.kind != OPK_NONE) begin
					countNext = 32'(countReg + 32'h1);
				end
			end
			default: begin
				stateNext = stateReg;
			end
		endcase
	end

	// Execute registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stateReg   <= ST_RUN;
			nopReg     <= 1'b0;
			insReg     <= '0;
			addrReg    <= '0;
			frReg      <= '0;
			pcLoadReg  <= 1'b0;
			flushReg   <= 1'b0;
			targetReg  <= '0;
			takenReg   <= 1'b0;
			foreignReg <= 1'b0;
			countReg   <= COUNT_RST;
		end else begin
			stateReg   <= stateNext;
			nopReg     <= nopNext;
			insReg     <= insNext;
			addrReg    <= addrNext;
			frReg      <= frNext;
			pcLoadReg  <= pcLoadNext;
			flushReg   <= flushNext;
			targetReg  <= targetNext;
			takenReg   <= takenNext;
			foreignReg <= foreignNext;
			countReg   <= countNext;
		end
	end

	// Software writes and reads; unmapped reads return zero
	always_comb begin
		ctrlNext   = ctrlReg;
		rdDataNext = 32'h0;
		if (swWr && swAddr == REG_CTRL) begin
			ctrlNext = swWrData[CTRL_W-1:0];
		end
		if (swRd) begin
			if (swAddr == REG_CTRL) begin
				rdDataNext = 32'(ctrlReg);
			end else if (swAddr == REG_STATUS) begin
				rdDataNext[ST_BIT_NOP]          = nopReg;
				rdDataNext[ST_BIT_TAKEN]        = takenReg;
				rdDataNext[ST_BIT_FOREIGN]      = foreignReg;
				rdDataNext[ST_KIND_LSB +: 3]    = insReg.kind;
			end else if (swAddr == REG_TARGET) begin
				rdDataNext = 32'(targetReg);
			end else if (swAddr == REG_COUNT) begin
				rdDataNext = countReg;
			end else begin
				rdDataNext = 32'h0;
			end
		end
	end

	// Software registers; a disable takes effect at the next Q1
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrlReg   <= CTRL_RST;
			rdDataReg <= 32'h0;
		end else begin
			ctrlReg   <= ctrlNext;
			rdDataReg <= rdDataNext;
		end
	end

	// Outputs straight from flops
	assign frReq      = frReg;
	assign pcLoad     = pcLoadReg;
	assign pcTarget   = targetReg;
	assign fetchFlush = flushReg;
	assign nopCycle   = nopReg;
	assign qPhase     = phase;
	assign swRdData   = rdDataReg;

endmodule : bbs_exec

// ==== hw/bbs_pkg.sv ====
// Shared constants, types and field layouts of the branch and bit-set execute block
package bbs_pkg;

	// Instruction encodings
	localparam logic [7:0] OP_NO_OVF    = 8'he5;  // Upper byte, branch on overflow clear
	localparam logic [7:0] OP_NONZERO   = 8'he1;  // Upper byte, branch on zero clear
	localparam logic [4:0] OP_ALWAYS    = 5'h1a;  // Top five bits, relative branch
	localparam logic [3:0] OP_SETBIT    = 4'h8;   // Top nibble, bit set in file register

	// Field positions inside the instruction word
	localparam int OP_BYTE_LSB   = 8;
	localparam int OP_FIVE_LSB   = 11;
	localparam int OP_NIB_LSB    = 12;
	localparam int BIT_POS_LSB   = 9;
	localparam int ACCESS_BIT    = 8;

	// Geometry of addresses
	localparam int PC_W_DEF      = 21;
	localparam int BSR_W         = 4;
	localparam int FR_ADDR_W     = 12;
	localparam int OFFSET_W      = 11;
	localparam logic [7:0] ACC_SPLIT_DEF   = 8'h80;  // Access bank low half ends here
	localparam logic [3:0] ACC_HI_BANK_DEF = 4'hf;   // Bank holding access bank high half
	localparam logic [3:0] ACC_LO_BANK     = 4'h0;   // Bank holding access bank low half

	// Software register offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_TARGET  = 8'h08;
	localparam logic [7:0] REG_COUNT   = 8'h0c;

	// Register fields and reset values
	localparam int CTRL_W         = 1;
	localparam int CTRL_BIT_EN    = 0;
	localparam logic [CTRL_W-1:0] CTRL_RST = 1'h1;
	localparam int ST_BIT_NOP     = 0;
	localparam int ST_BIT_TAKEN   = 1;
	localparam int ST_BIT_FOREIGN = 2;
	localparam int ST_KIND_LSB    = 4;
	localparam logic [31:0] COUNT_RST = 32'h0;

	// Timing: quadrature phases per instruction cycle, one clock each
	localparam int NUM_PHASES = 4;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} bbs_phase_t;

	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_NOP = 1'b1
	} bbs_state_t;

	typedef enum logic [2:0] {
		OPK_NONE  = 3'b000,
		OPK_NOOVF = 3'b001,
		OPK_NZ    = 3'b010,
		OPK_BRA   = 3'b011,
		OPK_BSF   = 3'b100
	} bbs_kind_t;

	typedef struct packed {
		bbs_kind_t             kind;
		logic [OFFSET_W-1:0]   offset;
		logic [2:0]            bitPos;
		logic                  access;
		logic [7:0]            fAddr;
	} bbs_decoded_t;

	typedef struct packed {
		logic [FR_ADDR_W-1:0]  addr;
		logic                  rdEn;
		logic                  wrEn;
		logic [7:0]            wrData;
	} bbs_frreq_t;

endpackage : bbs_pkg

// ==== hw/bbs_qphase.sv ====
// Quadrature phase sequencer: one phase per clock, four per instruction cycle
`timescale 1ns/1ps
module bbs_qphase
	import bbs_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Current phase
	output bbs_phase_t      phase
);

	bbs_phase_t phaseReg;
	bbs_phase_t phaseNext;

	// Wraps from Q4 back to Q1 by plain two-bit overflow
	always_comb begin
		phaseNext = bbs_phase_t'(2'(phaseReg + 2'h1));
	end

	// First instruction cycle starts at Q1 after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phaseReg <= PH_Q1;
		end else begin
			phaseReg <= phaseNext;
		end
	end

	assign phase = phaseReg;

endmodule : bbs_qphase

// ==== tb/bbs_exec_asserts.sv ====
// Concurrent checks on the ports of the branch and bit-set execute block
`timescale 1ns/1ps
module bbs_exec_asserts
	import bbs_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Watched ports
	input wire logic [15:0] instrWord,
	input wire logic        instrValid,
	input wire logic        ovfFlag,
	input wire logic        zeroFlag,
	input bbs_frreq_t       frReq,
	input wire logic [7:0]  frRdData,
	input wire logic        pcLoad,
	input wire logic        fetchFlush,
	input wire logic        nopCycle,
	input bbs_phase_t       qPhase
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Phase steps once per clock; guarded so the release edge is not judged
	a_phase_step: assert property ($past(resetn) |-> qPhase == bbs_phase_t'($past(qPhase) + 2'h1))
		else $error("phase did not advance");
	a_load_in_q4: assert property (pcLoad |-> qPhase == PH_Q4 && fetchFlush)
		else $error("pc load outside Q4 or without flush");
	a_nop_after: assert property (pcLoad |=> nopCycle [*4] ##1 !nopCycle)
		else $error("idle cycle not four phases");
	a_idle_quiet: assert property (nopCycle |-> !pcLoad && !frReq.rdEn && !frReq.wrEn)
		else $error("activity in idle cycle");
	a_rd_then_wr: assert property (frReq.rdEn |-> qPhase == PH_Q2 ##2 frReq.wrEn)
		else $error("bit set read and write not Q2 and Q4");
	// Only one bit may rise, and none may fall
	a_wr_sets_bit: assert property (frReq.wrEn |-> qPhase == PH_Q4
		&& (frReq.wrData & $past(frRdData)) == $past(frRdData)
		&& $countones(frReq.wrData ^ $past(frRdData)) <= 1)
		else $error("bit set write data wrong");
	a_noovf_cond: assert property (qPhase == PH_Q1 && instrValid && !nopCycle
		&& instrWord[15:8] == OP_NO_OVF |-> ##3 pcLoad == !$past(ovfFlag))
		else $error("overflow clear branch decision wrong");
	a_nz_cond: assert property (qPhase == PH_Q1 && instrValid && !nopCycle
		&& instrWord[15:8] == OP_NONZERO |-> ##3 pcLoad == !$past(zeroFlag))
		else $error("nonzero branch decision wrong");
	a_always_taken: assert property (qPhase == PH_Q1 && instrValid && !nopCycle
		&& instrWord[15:11] == OP_ALWAYS |-> ##3 pcLoad)
		else $error("relative branch not taken");
endmodule : bbs_exec_asserts

bind bbs_exec bbs_exec_asserts u_bbs_exec_asserts (.clk(clk), .resetn(resetn),
	.instrWord(instrWord), .instrValid(instrValid), .ovfFlag(ovfFlag), .zeroFlag(zeroFlag),
	.frReq(frReq), .frRdData(frRdData), .pcLoad(pcLoad), .fetchFlush(fetchFlush),
	.nopCycle(nopCycle), .qPhase(qPhase));

// ==== tb/tb.sv ====
// Self-checking bench for the branch and bit-set execute block
`timescale 1ns/1ps
module tb;
	import bbs_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [15:0] instrWord = 16'h0;
	logic        instrValid = 1'b0;
	logic [20:0] instrAddr = 21'h0;
	logic        ovfFlag = 1'b0;
	logic        zeroFlag = 1'b0;
	logic [3:0]  bankSel = 4'h0;
	logic [7:0]  frRdData = 8'h0;
	logic [7:0]  swAddr = 8'h0;
	logic [31:0] swWrData = 32'h0;
	logic        swWr = 1'b0;
	logic        swRd = 1'b0;
	bbs_frreq_t  frReq;
	logic        pcLoad;
	logic        fetchFlush;
	logic        nopCycle;
	logic [20:0] pcTarget;
	bbs_phase_t  qPhase;
	logic [31:0] swRdData;
	int          miscompares = 0;
	int          numChecks = 0;
	int          cycles = 0;

	bbs_exec u_bbs_exec (.clk(clk), .resetn(resetn), .instrWord(instrWord),
		.instrValid(instrValid), .instrAddr(instrAddr), .ovfFlag(ovfFlag),
		.zeroFlag(zeroFlag), .bankSel(bankSel), .frReq(frReq), .frRdData(frRdData),
		.pcLoad(pcLoad), .pcTarget(pcTarget), .fetchFlush(fetchFlush),
		.nopCycle(nopCycle), .qPhase(qPhase), .swAddr(swAddr), .swWrData(swWrData),
		.swWr(swWr), .swRd(swRd), .swRdData(swRdData));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	task automatic reportAndStop();
		if (miscompares == 0 && numChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : reportAndStop

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			reportAndStop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One instruction offered in Q1, outputs judged at the falling edges of Q2, Q4 and the next Q1
	task automatic run(input logic [15:0] w, input logic [20:0] pa, input logic ov,
		input logic zf, input logic ld, input logic [20:0] tgt, input logic isSet,
		input logic [11:0] fa, input logic [7:0] fd);
		do @(negedge clk); while (qPhase !== PH_Q4);
		@(posedge clk);
		instrWord <= w;
		instrValid <= 1'b1;
		instrAddr <= pa;
		ovfFlag <= ov;
		zeroFlag <= zf;
		frRdData <= 8'h0a;
		@(posedge clk);
		instrValid <= 1'b0;
		@(negedge clk);
		chk("rdEn", isSet, frReq.rdEn);
		repeat (2) @(negedge clk);
		chk("pcLoad", ld, pcLoad);
		chk("fetchFlush", ld, fetchFlush);
		chk("wrEn", isSet, frReq.wrEn);
		if (ld) chk("pcTarget", tgt, pcTarget);
		if (isSet) chk("frAddr", fa, frReq.addr);
		if (isSet) chk("wrData", fd, frReq.wrData);
		@(negedge clk);
		chk("nopCycle", ld, nopCycle);
	endtask : run

	// Both conditional branches, each flag state, both offset extremes
	task automatic t_cond();
		logic [7:0] off;
		for (int i = 0; i < 4; i++) begin
			off = i[1] ? 8'h80 : 8'h7f;
			run({OP_NO_OVF, off}, 21'h01000, i[0], !i[0], !i[0],
				21'h01002 + {{12{off[7]}}, off, 1'b0}, 1'b0, 12'h0, 8'h0);
			run({OP_NONZERO, off}, 21'h01000, !i[0], i[0], !i[0],
				21'h01002 + {{12{off[7]}}, off, 1'b0}, 1'b0, 12'h0, 8'h0);
		end
	endtask : t_cond

	// Relative branch at offset extremes; a near pattern must not branch
	task automatic t_always();
		logic [10:0] offs [3] = '{11'h400, 11'h3ff, 11'h001};
		run(16'hd800, 21'h00800, 1'b0, 1'b0, 1'b0, 21'h0, 1'b0, 12'h0, 8'h0);
		foreach (offs[i]) begin
			run({OP_ALWAYS, offs[i]}, 21'h00800, 1'b1, 1'b1, 1'b1,
				21'h00802 + {{9{offs[i][10]}}, offs[i], 1'b0}, 1'b0, 12'h0, 8'h0);
		end
	endtask : t_always

	// Every bit position, both access modes, both halves of the access bank
	task automatic t_setbit();
		logic [7:0]  f;
		logic [11:0] ea;
		@(posedge clk);
		bankSel <= 4'h5;
		for (int b = 0; b < 8; b++) begin
			f = (b < 4) ? 8'h7f : 8'h80;
			ea = b[0] ? {4'h5, f} : (f < ACC_SPLIT_DEF ? {ACC_LO_BANK, f} : {ACC_HI_BANK_DEF, f});
			run({OP_SETBIT, b[2:0], b[0], f}, 21'h0, 1'b0, 1'b0, 1'b0, 21'h0, 1'b1,
				ea, 8'h0a | (8'h01 << b));
		end
	endtask : t_setbit

	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		swAddr <= a;
		swWrData <= d;
		swWr <= 1'b1;
		@(posedge clk);
		swWr <= 1'b0;
	endtask : sw_write

	task automatic sw_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		swAddr <= a;
		swRd <= 1'b1;
		@(posedge clk);
		swRd <= 1'b0;
		@(negedge clk);
		chk("swRdData", exp, swRdData);
	endtask : sw_read

	// Register port: reset value, read-only write, unmapped read, last target,
	// status and count after the branch runs, and the enable bit turned off
	task automatic t_regs();
		sw_read(REG_CTRL, 32'h1);
		sw_write(REG_TARGET, 32'hffffffff);
		sw_read(REG_TARGET, 32'h00804);
		sw_read(8'h10, 32'h0);
		sw_read(REG_STATUS, 32'h2);
		sw_read(REG_COUNT, 32'hb);
		// Disabled core must ignore an offered bit set and leave the count alone
		sw_write(REG_CTRL, 32'h0);
		sw_read(REG_CTRL, 32'h0);
		run(16'h8a7f, 21'h0, 1'b0, 1'b0, 1'b0, 21'h0, 1'b0, 12'h0, 8'h0);
		sw_read(REG_COUNT, 32'hb);
		sw_write(REG_CTRL, 32'h1);
		sw_read(REG_CTRL, 32'h1);
	endtask : t_regs

	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_cond();
		t_always();
		t_regs();
		t_setbit();
		reportAndStop();
	end
endmodule : tb
